/* File: pcg_pkg.sv */
// Constants shared by the serial configuration block of the clock generator.
package pcg_pkg;
  localparam int REG_COUNT = 16;
  localparam int PTR_W     = 4;
  // Seven-bit slave address with the strap-controlled bit position.
  localparam logic [6:0] DEV_ADDR_BASE = 7'h58;
  localparam int         ADDR_STRAP_BIT = 2;
  // Register indexes.
  localparam logic [3:0] REG_A_REF     = 4'h0;
  localparam logic [3:0] REG_A_FB      = 4'h1;
  localparam logic [3:0] REG_A_CTRL    = 4'h2;
  localparam logic [3:0] REG_B_REF     = 4'h3;
  localparam logic [3:0] REG_B_FB      = 4'h4;
  localparam logic [3:0] REG_B_CTRL    = 4'h5;
  localparam logic [3:0] REG_C1_REF    = 4'h6;
  localparam logic [3:0] REG_C1_FB     = 4'h7;
  localparam logic [3:0] REG_C1_CTRL   = 4'h8;
  localparam logic [3:0] REG_C2_REF    = 4'h9;
  localparam logic [3:0] REG_C2_FB     = 4'hA;
  localparam logic [3:0] REG_C2_CTRL   = 4'hB;
  localparam logic [3:0] REG_POST_AB   = 4'hC;
  localparam logic [3:0] REG_POST_CD1  = 4'hD;
  localparam logic [3:0] REG_POST_CD2  = 4'hE;
  localparam logic [3:0] REG_MUX_SLEEP = 4'hF;
  // Write mask of the alternate third-loop control byte; bit 5 is reserved.
  localparam logic [7:0] C2_CTRL_MASK  = 8'hDF;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         SLEEP_BIT     = 5;
  typedef enum logic [2:0] {PCG_IDLE, PCG_ADDR, PCG_ADDR_ACK, PCG_WRX, PCG_WR_ACK,
                            PCG_RDX, PCG_RD_ACK} pcg_state_t;
endpackage

/* File: pcg_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module pcg_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doPush;
  logic             doPop;
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule // pcg_fifo

/* File: pcg_serial_regs.sv */
// Two-wire slave and sixteen-byte configuration file of a three-loop clock generator.
// Operation
// - First byte after write address loads register pointer.
// - Pointer advances after each stored byte.
// - Pointer wraps after sixteen bytes.
// - Every received data byte is acknowledged.
// - Byte takes effect at its acknowledge.
// - Read pointer increments after each byte.
// - Repeated start keeps pointer, then read.
// - Read sends bytes, wrapping past fifteen.
// - All registers clear at reset.
// - Select pin picks alternate post nibbles.
// - Feedback divider is eleven bits split.
// - Primary third-loop set in bytes 6-8.
// - Loop fields pass straight to loops; loop C top bit is zero on the alternate set.
// - Mux and post fields pass directly.
// - Sleep bits choose powered-down sections.
// - Slave address with strap bit A2.
// - Select pin switches C/D sets.
// - Sleep pin gates enabled sections only.
`timescale 1ns/100ps
module pcg_serial_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        addrSelectPin,
  input  wire logic        freqSetSelectPin,
  input  wire logic        sleepRequestPin,
  output logic      [7:0]  refDivA,
  output logic      [10:0] feedbackDivA,
  output logic      [7:0]  refDivB,
  output logic      [10:0] feedbackDivB,
  output logic      [7:0]  refDivC,
  output logic      [10:0] feedbackDivC,
  output logic      [2:0]  loopCtrlA,
  output logic      [2:0]  loopCtrlB,
  output logic      [2:0]  loopCtrlC,
  output logic      [1:0]  muxA,
  output logic      [1:0]  muxB,
  output logic      [1:0]  muxC,
  output logic      [1:0]  muxD,
  output logic      [3:0]  postDivA,
  output logic      [3:0]  postDivB,
  output logic      [3:0]  postDivC,
  output logic      [3:0]  postDivD,
  output logic      [2:0]  loopSleep,
  output logic      [3:0]  dividerSleep
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] selSync;
  logic [1:0] sleepSync;
  logic [1:0] strapSync;
  logic       sclPrev;
  logic       sdaPrev;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclSync   <= 2'h3;
      sdaSync   <= 2'h3;
      selSync   <= 2'h0;
      sleepSync <= 2'h0;
      strapSync <= 2'h3;
      sclPrev   <= 1'b1;
      sdaPrev   <= 1'b1;
    end else begin
      sclSync   <= {sclSync[0], sclIn};
      sdaSync   <= {sdaSync[0], sdaIn};
      selSync   <= {selSync[0], freqSetSelectPin};
      sleepSync <= {sleepSync[0], sleepRequestPin};
      strapSync <= {strapSync[0], addrSelectPin};
      sclPrev   <= sclSync[1];
      sdaPrev   <= sdaSync[1];
    end
  end
  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign scl       = sclSync[1];
  assign sda       = sdaSync[1];
  assign sclRise   = scl && !sclPrev;
  assign sclFall   = !scl && sclPrev;
  assign startCond = scl && sclPrev && sdaPrev && !sda;
  assign stopCond  = scl && sclPrev && !sdaPrev && sda;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  pcg_pkg::pcg_state_t state;
  logic [7:0]  shiftReg;
  logic [3:0]  bitCnt;
  logic        haveReg;
  logic        isRead;
  logic [3:0]  regPtr;
  logic [7:0]  txByte;
  logic [7:0]  regs [pcg_pkg::REG_COUNT];
  logic [6:0]  myAddr;
  logic        fifoInValid;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [11:0] fifoOutData;

  always_comb begin
    myAddr = pcg_pkg::DEV_ADDR_BASE;
    myAddr[pcg_pkg::ADDR_STRAP_BIT] = strapSync[1];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state    <= pcg_pkg::PCG_IDLE;
      shiftReg <= 8'h00;
      bitCnt   <= 4'h0;
      haveReg  <= 1'b0;
      isRead   <= 1'b0;
      regPtr   <= 4'h0;
      txByte   <= 8'h00;
      sdaOe    <= 1'b0;
    end else if (startCond) begin
      state   <= pcg_pkg::PCG_ADDR;
      bitCnt  <= 4'h0;
      haveReg <= 1'b0;
      sdaOe   <= 1'b0;
    end else if (stopCond) begin
      state <= pcg_pkg::PCG_IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state)
        pcg_pkg::PCG_IDLE: begin
          sdaOe <= 1'b0;
        end
        pcg_pkg::PCG_ADDR, pcg_pkg::PCG_WRX: begin
          if (sclRise) begin
            shiftReg <= {shiftReg[6:0], sda};
            bitCnt   <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == 4'h8) begin
            bitCnt <= 4'h0;
            if (state == pcg_pkg::PCG_ADDR) begin
              if (shiftReg[7:1] == myAddr) begin
                isRead <= shiftReg[0];
                sdaOe  <= 1'b1;
                state  <= pcg_pkg::PCG_ADDR_ACK;
                txByte <= regs[regPtr];
              end else begin
                state <= pcg_pkg::PCG_IDLE;
              end
            end else if (fifoInReady || !haveReg) begin
              sdaOe <= 1'b1;
              state <= pcg_pkg::PCG_WR_ACK;
              if (!haveReg) begin
                regPtr  <= shiftReg[3:0];
                haveReg <= 1'b1;
              end else begin
                regPtr <= regPtr + 4'h1;
              end
            end else begin
              state <= pcg_pkg::PCG_IDLE;
            end
          end
        end
        pcg_pkg::PCG_ADDR_ACK, pcg_pkg::PCG_WR_ACK: begin
          if (sclFall) begin
            if (state == pcg_pkg::PCG_ADDR_ACK && isRead) begin
              state  <= pcg_pkg::PCG_RDX;
              sdaOe  <= !txByte[7];
              txByte <= {txByte[6:0], 1'b0};
              bitCnt <= 4'h1;
            end else begin
              sdaOe <= 1'b0;
              state <= pcg_pkg::PCG_WRX;
            end
          end
        end
        pcg_pkg::PCG_RDX: begin
          if (sclFall) begin
            if (bitCnt == 4'h8) begin
              sdaOe  <= 1'b0;
              state  <= pcg_pkg::PCG_RD_ACK;
              regPtr <= regPtr + 4'h1;
            end else begin
              sdaOe  <= !txByte[7];
              txByte <= {txByte[6:0], 1'b0};
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        pcg_pkg::PCG_RD_ACK: begin
          if (sclRise) begin
            if (sda) begin
              state <= pcg_pkg::PCG_IDLE;
            end else begin
              txByte <= regs[regPtr];
            end
          end else if (sclFall) begin
            state  <= pcg_pkg::PCG_RDX;
            sdaOe  <= !txByte[7];
            txByte <= {txByte[6:0], 1'b0};
            bitCnt <= 4'h1;
          end
        end
        default: begin
          state <= pcg_pkg::PCG_IDLE;
        end
      endcase
    end
  end
  assign sdaOut = 1'b0;

  // ----------------------------------------------------------------
  // Write path through the FIFO, then the register file
  // ----------------------------------------------------------------
  assign fifoInValid = (state == pcg_pkg::PCG_WRX) && sclFall && (bitCnt == 4'h8) && haveReg
                       && !startCond && !stopCond;
  logic [3:0] wrIdx;
  logic       fifoOutReady;
  assign fifoOutReady = 1'b1;

  pcg_fifo #(
    .WIDTH(12),
    .DEPTH(4)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   ({regPtr, shiftReg}),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );
  assign wrIdx = fifoOutData[11:8];

  genvar gi;
  generate
    for (gi = 0; gi < pcg_pkg::REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          regs[gi] <= pcg_pkg::REG_RESET;
        end else if (fifoOutValid && wrIdx == 4'(gi)) begin
          regs[gi] <= (4'(gi) == pcg_pkg::REG_C2_CTRL) ? (fifoOutData[7:0] & pcg_pkg::C2_CTRL_MASK)
                                                       : fifoOutData[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Field decode to the clock sections
  // ----------------------------------------------------------------
  logic sel;
  assign sel = selSync[1];
  assign refDivA      = regs[pcg_pkg::REG_A_REF];
  assign feedbackDivA = {regs[pcg_pkg::REG_A_CTRL][2:0], regs[pcg_pkg::REG_A_FB]};
  assign loopCtrlA    = regs[pcg_pkg::REG_A_CTRL][5:3];
  assign muxA         = regs[pcg_pkg::REG_A_CTRL][7:6];
  assign refDivB      = regs[pcg_pkg::REG_B_REF];
  assign feedbackDivB = {regs[pcg_pkg::REG_B_CTRL][2:0], regs[pcg_pkg::REG_B_FB]};
  assign loopCtrlB    = regs[pcg_pkg::REG_B_CTRL][5:3];
  assign muxB         = regs[pcg_pkg::REG_B_CTRL][7:6];
  assign refDivC      = sel ? regs[pcg_pkg::REG_C2_REF] : regs[pcg_pkg::REG_C1_REF];
  assign feedbackDivC = sel ? {regs[pcg_pkg::REG_C2_CTRL][2:0], regs[pcg_pkg::REG_C2_FB]}
                            : {regs[pcg_pkg::REG_C1_CTRL][2:0], regs[pcg_pkg::REG_C1_FB]};
  assign loopCtrlC    = {sel ? 1'b0 : regs[pcg_pkg::REG_C1_CTRL][5],
                         sel ? regs[pcg_pkg::REG_C2_CTRL][4:3] : regs[pcg_pkg::REG_C1_CTRL][4:3]};
  assign muxC         = sel ? regs[pcg_pkg::REG_MUX_SLEEP][5:4] : regs[pcg_pkg::REG_C1_CTRL][7:6];
  assign muxD         = sel ? regs[pcg_pkg::REG_MUX_SLEEP][7:6] : regs[pcg_pkg::REG_C2_CTRL][7:6];
  assign postDivA     = regs[pcg_pkg::REG_POST_AB][3:0];
  assign postDivB     = regs[pcg_pkg::REG_POST_AB][7:4];
  assign postDivC     = sel ? regs[pcg_pkg::REG_POST_CD2][3:0] : regs[pcg_pkg::REG_POST_CD1][3:0];
  assign postDivD     = sel ? regs[pcg_pkg::REG_POST_CD2][7:4] : regs[pcg_pkg::REG_POST_CD1][7:4];
  assign loopSleep    = {3{sleepSync[1]}} & {regs[pcg_pkg::REG_C1_CTRL][pcg_pkg::SLEEP_BIT],
                                            regs[pcg_pkg::REG_B_CTRL][pcg_pkg::SLEEP_BIT],
                                            regs[pcg_pkg::REG_A_CTRL][pcg_pkg::SLEEP_BIT]};
  assign dividerSleep = {4{sleepSync[1]}} & regs[pcg_pkg::REG_MUX_SLEEP][3:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ptrAdv;
    @(posedge clk_sys) disable iff (rst)
    (fifoInValid && fifoInReady) |=> (regPtr == $past(regPtr) + 4'h1);
  endproperty
  a_ptrAdv: assert property (p_ptrAdv) else $error("pointer did not advance");
  // The pointer moves on at the push, so the checker keeps its own copy of target and byte.
  logic [3:0] lastWrIdx;
  logic [7:0] lastWrData;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lastWrIdx  <= 4'h0;
      lastWrData <= 8'h00;
    end else if (fifoInValid && fifoInReady) begin
      lastWrIdx  <= regPtr;
      lastWrData <= shiftReg;
    end
  end
  property p_update;
    @(posedge clk_sys) disable iff (rst)
    (fifoInValid && fifoInReady && regPtr != pcg_pkg::REG_C2_CTRL)
      |=> ##[0:3] (regs[lastWrIdx] == lastWrData);
  endproperty
  a_update: assert property (p_update) else $error("register not updated");
  property p_resv;
    @(posedge clk_sys) disable iff (rst) regs[pcg_pkg::REG_C2_CTRL][5] == 1'b0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_ack;
    @(posedge clk_sys) disable iff (rst)
    (state == pcg_pkg::PCG_WR_ACK) |-> sdaOe;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack driven");
  property p_sleep;
    @(posedge clk_sys) disable iff (rst) !sleepSync[1] |-> (dividerSleep == 4'h0 && loopSleep == 3'h0);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without pin");
  property p_rdInc;
    @(posedge clk_sys) disable iff (rst)
    (state == pcg_pkg::PCG_RDX && sclFall && bitCnt == 4'h8 && !startCond && !stopCond)
      |=> (regPtr == $past(regPtr) + 4'h1);
  endproperty
  a_rdInc: assert property (p_rdInc) else $error("read pointer stuck");
  property p_post;
    @(posedge clk_sys) disable iff (rst)
    postDivC == (selSync[1] ? regs[pcg_pkg::REG_POST_CD2][3:0] : regs[pcg_pkg::REG_POST_CD1][3:0]);
  endproperty
  a_post: assert property (p_post) else $error("post nibble set wrong");
  property p_idleOe;
    @(posedge clk_sys) disable iff (rst) $rose(state == pcg_pkg::PCG_IDLE) |=> !sdaOe;
  endproperty
  a_idleOe: assert property (p_idleOe) else $error("sda driven when idle");
  c_write: cover property (@(posedge clk_sys) fifoInValid && fifoInReady);
  c_read: cover property (@(posedge clk_sys) state == pcg_pkg::PCG_RD_ACK);
  c_wrap: cover property (@(posedge clk_sys) fifoInValid && regPtr == 4'hF);
endmodule // pcg_serial_regs

/* File: pcg_i2c_master.sv */
// Behavioural two-wire bus master that drives the configuration port.
`timescale 1ns/100ps
module pcg_i2c_master #(
  parameter int QTR = 5
) (
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output logic      sclLine,
  output logic      sdaRelease
);
  // ----------------------------------------
  // Bus idles released, both lines high.
  // ----------------------------------------
  initial begin
    sclLine    = 1'b1;
    sdaRelease = 1'b1;
  end

  task automatic qwait();
    repeat (QTR) @(posedge clk_sys);
  endtask

  task automatic start();
    sclLine <= 1'b0;
    qwait();
    sdaRelease <= 1'b1;
    qwait();
    sclLine <= 1'b1;
    qwait();
    sdaRelease <= 1'b0;
    qwait();
  endtask

  task automatic stop();
    sclLine <= 1'b0;
    qwait();
    sdaRelease <= 1'b0;
    qwait();
    sclLine <= 1'b1;
    qwait();
    sdaRelease <= 1'b1;
    qwait();
  endtask

  // Data changes only while the clock is low and is sampled mid-high.
  task automatic bitTx(input logic b, output logic s);
    sclLine <= 1'b0;
    qwait();
    sdaRelease <= b;
    qwait();
    sclLine <= 1'b1;
    qwait();
    s = sdaLine;
    qwait();
  endtask

  // Next byte only after the acknowledge slot.
  task automatic byteXfer(input logic [7:0] d, input logic ackOut, output logic [7:0] q, output logic ackIn);
    for (int i = 7; i >= 0; i--) begin
      bitTx(d[i], q[i]);
    end
    bitTx(ackOut, ackIn);
  endtask
endmodule // pcg_i2c_master

/* File: pcg_serial_regs_tb_top.sv */
// Self-checking bench for the two-wire configuration port.
`timescale 1ns/100ps
module pcg_serial_regs_tb_top;
  logic        clk_sys          = 1'b0;
  logic        rst              = 1'b1;
  logic        addrSelectPin    = 1'b1;
  logic        freqSetSelectPin = 1'b0;
  logic        sleepRequestPin  = 1'b0;
  logic        sclLine;
  logic        sdaRelease;
  logic        sdaOut;
  logic        sdaOe;
  logic        sdaLine;
  logic [7:0]  refDivA, refDivB, refDivC;
  logic [10:0] feedbackDivA, feedbackDivB, feedbackDivC;
  logic [2:0]  loopCtrlA, loopCtrlB, loopCtrlC, loopSleep;
  logic [1:0]  muxA, muxB, muxC, muxD;
  logic [3:0]  postDivA, postDivB, postDivC, postDivD, dividerSleep;
  logic [7:0]  shadow [16] = '{default: 8'h00};
  int          err_count    = 0;
  int          check_count  = 0;

  // ----------------------------------------
  // Clock, open-drain wire and instances.
  // ----------------------------------------
  always #5 clk_sys = ~clk_sys;

  assign sdaLine = (sdaOe ? sdaOut : 1'b1) & sdaRelease;

  pcg_i2c_master MST (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclLine(sclLine), .sdaRelease(sdaRelease));

  pcg_serial_regs DUT (
    .clk_sys(clk_sys), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectPin(addrSelectPin), .freqSetSelectPin(freqSetSelectPin), .sleepRequestPin(sleepRequestPin),
    .refDivA(refDivA), .feedbackDivA(feedbackDivA), .refDivB(refDivB), .feedbackDivB(feedbackDivB),
    .refDivC(refDivC), .feedbackDivC(feedbackDivC), .loopCtrlA(loopCtrlA), .loopCtrlB(loopCtrlB),
    .loopCtrlC(loopCtrlC), .muxA(muxA), .muxB(muxB), .muxC(muxC), .muxD(muxD), .postDivA(postDivA),
    .postDivB(postDivB), .postDivC(postDivC), .postDivD(postDivD), .loopSleep(loopSleep),
    .dividerSleep(dividerSleep)
  );

  // ----------------------------------------
  // Shared helpers.
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Slave address follows the select pin in bit two.
  function automatic logic [6:0] devAddr();
    return {4'b1011, addrSelectPin, 2'b00};
  endfunction

  task automatic addrPhase(input logic [7:0] ptr);
    logic [7:0] q;
    logic       a;
    MST.start();
    MST.byteXfer({devAddr(), 1'b0}, 1'b1, q, a);
    check(a, 1'b0);
    MST.byteXfer(ptr, 1'b1, q, a);
    check(a, 1'b0);
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic testRead(input logic [3:0] st);
    logic [7:0] q;
    logic       a;
    addrPhase({4'h0, st});
    MST.start();
    MST.byteXfer({devAddr(), 1'b1}, 1'b1, q, a);
    check(a, 1'b0);
    for (int i = 0; i < 16; i++) begin
      MST.byteXfer(8'hFF, i == 15, q, a);
      check(q, shadow[(st + i) % 16]);
    end
    MST.stop();
    $display("read from %h done", st);
  endtask

  task automatic testWrite();
    logic [7:0] q;
    logic [7:0] d;
    logic       a;
    addrPhase(8'h00);
    for (int i = 0; i < 18; i++) begin
      d = 8'(8'h37 * (i + 1) + i);
      shadow[i % 16] = d;
      MST.byteXfer(d, 1'b1, q, a);
      check(a, 1'b0);
      if (i == 0 || i == 16) check(refDivA, d);
    end
    MST.stop();
    $display("sequential write done");
  endtask

  task automatic testDecode();
    check(feedbackDivA, {shadow[2][2:0], shadow[1]});
    check(muxA, shadow[2][7:6]);
    check(postDivA, shadow[12][3:0]);
    check(refDivC, shadow[6]);
    check(feedbackDivC, {shadow[8][2:0], shadow[7]});
    check(postDivD, shadow[13][7:4]);
    check(postDivC, shadow[13][3:0]);
    check(feedbackDivB, {shadow[5][2:0], shadow[4]});
    check(loopCtrlA, shadow[2][5:3]);
    check(loopCtrlB, shadow[5][5:3]);
    check(loopCtrlC, shadow[8][5:3]);
    check(muxB, shadow[5][7:6]);
    check(postDivB, shadow[12][7:4]);
    check(muxC, shadow[8][7:6]);
    check(muxD, shadow[11][7:6]);
    freqSetSelectPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(refDivC, shadow[9]);
    check(feedbackDivC, {shadow[11][2:0], shadow[10]});
    check(postDivC, shadow[14][3:0]);
    check(muxD, shadow[15][7:6]);
    check(muxC, shadow[15][5:4]);
    check(postDivD, shadow[14][7:4]);
    check(loopCtrlC, {1'b0, shadow[11][4:3]});
    freqSetSelectPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(loopSleep, 3'b000);
    check(dividerSleep, 4'h0);
    sleepRequestPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(loopSleep, {shadow[8][5], shadow[5][5], shadow[2][5]});
    check(dividerSleep, shadow[15][3:0]);
    sleepRequestPin <= 1'b0;
    $display("field decode done");
  endtask

  task automatic testWrap();
    logic [7:0] q;
    logic       a;
    addrPhase(8'h1B);
    MST.byteXfer(8'hFF, 1'b1, q, a);
    MST.stop();
    shadow[11] = 8'hDF;
    addrPhase(8'h13);
    MST.byteXfer(8'h5A, 1'b1, q, a);
    MST.stop();
    shadow[3] = 8'h5A;
    check(refDivB, 8'h5A);
    testRead(4'hA);
    $display("pointer wrap done");
  endtask

  task automatic testReset();
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    shadow = '{default: 8'h00};
    check(refDivB, 8'h00);
    testRead(4'h3);
    $display("reset clear done");
  endtask

  task automatic testAddr();
    logic [7:0] q;
    logic       a;
    addrSelectPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    MST.start();
    MST.byteXfer({7'b1011100, 1'b0}, 1'b1, q, a);
    check(a, 1'b1);
    MST.stop();
    check(sdaOe, 1'b0);
    addrPhase(8'h00);
    MST.stop();
    addrSelectPin <= 1'b1;
    $display("address select done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    testRead(4'h0);
    testWrite();
    testDecode();
    testRead(4'h5);
    testWrap();
    testReset();
    testAddr();
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule // pcg_serial_regs_tb_top
